// *** hdl/pcs_pkg.sv ***
// Package of constants and carrier types for the program counter and stack block.
package pcs_pkg;

	// ==========================================================
	// Widths and layout
	localparam int PC_W         = 13;
	localparam int STACK_DEPTH  = 8;
	localparam int SP_W         = 3;
	localparam int ADDR_FIELD_W = 11;
	localparam int LATCH_LO_W   = 5;
	localparam int DADDR_W      = 9;
	localparam int JUMP_HI_LSB  = 3;

	// ==========================================================
	// AXI4-Lite register offsets
	localparam logic [7:0] PC_LOW_BYTE_OFF  = 8'h00;
	localparam logic [7:0] PC_HIGH_LATCH_OFF = 8'h04;
	localparam logic [7:0] FILE_SELECT_OFF  = 8'h08;
	localparam logic [7:0] PC_FULL_OFF      = 8'h0c;
	localparam logic [7:0] STACK_PTR_OFF    = 8'h10;

	// ==========================================================
	// Reset values and fixed answers
	localparam logic [PC_W-1:0] PC_RESET    = 13'h0000;
	localparam logic [7:0]      LATCH_RESET = 8'h00;
	localparam logic [7:0]      FSEL_RESET  = 8'h00;
	localparam logic [SP_W-1:0] SP_RESET    = 3'h0;
	localparam logic [7:0]      INDIRECT_ADDR = 8'h00;
	localparam logic [7:0]      INDIRECT_READ = 8'h00;
	localparam logic [1:0]      RESP_OKAY   = 2'h0;
	localparam logic [1:0]      RESP_SLVERR = 2'h2;

	// ==========================================================
	// Program-flow command from the decoder
	typedef enum logic [2:0] {
		PCS_INC,
		PCS_HOLD,
		PCS_JUMP,
		PCS_CALL,
		PCS_RETURN,
		PCS_VECTOR
	} pcs_op_type;

	typedef struct packed {
		pcs_op_type             op;
		logic [ADDR_FIELD_W-1:0] target;
		logic [PC_W-1:0]        vector;
		logic                   low_wr;
		logic [7:0]             low_data;
	} pcs_flow_type;

	typedef struct packed {
		logic       bank;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} pcs_ind_type;

endpackage

// *** hdl/pcs_core.sv ***
// Program counter, circular return stack and indirect addressing logic.
`timescale 1ns/10ps
`default_nettype none

module pcs_core
	import pcs_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                nrst,
	input  wire logic                clk_en,
	input  wire pcs_flow_type        flow,
	input  wire pcs_ind_type         ind,
	input  wire logic [7:0]          ind_mem_rdata,
	output var  logic [PC_W-1:0]     pc,
	output var  logic [DADDR_W-1:0]  ind_addr,
	output var  logic                ind_mem_wr,
	output var  logic [7:0]          ind_mem_wdata,
	output var  logic [7:0]          ind_rdata,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output var  logic                s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output var  logic                s_axi_wready,
	output var  logic [1:0]          s_axi_bresp,
	output var  logic                s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output var  logic                s_axi_arready,
	output var  logic [31:0]         s_axi_rdata,
	output var  logic [1:0]          s_axi_rresp,
	output var  logic                s_axi_rvalid,
	input  wire logic                s_axi_rready
);

	// ==========================================================
	// State
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] pc_d;
	logic [7:0]      latch_q;
	logic [7:0]      fsel_q;
	logic [SP_W-1:0] sp_q;
	logic [SP_W-1:0] sp_d;
	logic [PC_W-1:0] stack_q [STACK_DEPTH];

	// ==========================================================
	// AXI4-Lite write path
	logic            aw_got_q;
	logic            w_got_q;
	logic [7:0]      aw_q;
	logic [31:0]     wd_q;
	logic [3:0]      ws_q;
	wire             aw_take  = s_axi_awvalid & s_axi_awready;
	wire             w_take   = s_axi_wvalid & s_axi_wready;
	wire             wr_fire  = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire             wr_low   = wr_fire & (aw_q == PC_LOW_BYTE_OFF) & ws_q[0];
	wire             wr_latch = wr_fire & (aw_q == PC_HIGH_LATCH_OFF) & ws_q[0];
	wire             wr_fsel  = wr_fire & (aw_q == FILE_SELECT_OFF) & ws_q[0];
	wire             wr_map   = (aw_q == PC_LOW_BYTE_OFF) |
	                            (aw_q == PC_HIGH_LATCH_OFF) |
	                            (aw_q == FILE_SELECT_OFF);
	// Next-cycle occupancy, so the ready outputs can come from flops.
	wire             aw_held  = ~wr_fire & (aw_got_q | aw_take);
	wire             w_held   = ~wr_fire & (w_got_q | w_take);
	wire             b_busy   = wr_fire | (s_axi_bvalid & ~s_axi_bready);

	// ==========================================================
	// Program counter next value
	wire             any_low  = flow.low_wr | wr_low;
	wire [7:0]       low_val  = flow.low_wr ? flow.low_data : wd_q[7:0];
	wire [PC_W-1:0]  pc_inc   = pc_q + 13'h0001;
	wire [PC_W-1:0]  pc_jump  = {latch_q[LATCH_LO_W-1:JUMP_HI_LSB],
	                             flow.target};
	wire [PC_W-1:0]  pc_lowld = {latch_q[LATCH_LO_W-1:0], low_val};
	wire [SP_W-1:0]  sp_dec   = sp_q - 3'h1;
	wire [PC_W-1:0]  pop_val  = stack_q[sp_dec];
	wire             do_push  = clk_en & ((flow.op == PCS_CALL) |
	                            (flow.op == PCS_VECTOR));
	wire [PC_W-1:0]  push_val = pc_inc;

	always_comb begin
		pc_d = pc_q;
		sp_d = sp_q;
		unique case (flow.op)
			PCS_INC:    pc_d = pc_inc;
			PCS_HOLD:   pc_d = pc_q;
			PCS_JUMP:   pc_d = pc_jump;
			PCS_CALL: begin
				pc_d = pc_jump;
				sp_d = sp_q + 3'h1;
			end
			PCS_RETURN: begin
				pc_d = pop_val;
				sp_d = sp_dec;
			end
			PCS_VECTOR: begin
				pc_d = flow.vector;
				sp_d = sp_q + 3'h1;
			end
			default:    pc_d = pc_q;
		endcase
		if (any_low) begin
			pc_d = pc_lowld;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pc_q <= PC_RESET;
			sp_q <= SP_RESET;
		end else if (clk_en) begin
			pc_q <= pc_d;
			sp_q <= sp_d;
		end
	end

	// Stack storage is a private array with no bus or data-space path.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_q[i] <= PC_RESET;
			end
		end else if (do_push) begin
			stack_q[sp_q] <= push_val;
		end
	end

	// The latch changes only on a bus write, never on push or pop.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			latch_q <= LATCH_RESET;
			fsel_q  <= FSEL_RESET;
		end else if (clk_en) begin
			if (wr_latch) begin
				latch_q <= {3'h0, wd_q[LATCH_LO_W-1:0]};
			end
			if (wr_fsel) begin
				fsel_q <= wd_q[7:0];
			end
		end
	end

	// ==========================================================
	// Indirect addressing
	wire             self_sel = (fsel_q == INDIRECT_ADDR);
	wire [DADDR_W-1:0] eff_addr = {ind.bank, fsel_q};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ind_addr      <= '0;
			ind_mem_wr    <= 1'b0;
			ind_mem_wdata <= 8'h00;
			ind_rdata     <= 8'h00;
		end else if (clk_en) begin
			ind_addr      <= eff_addr;
			ind_mem_wr    <= ind.wr & ~self_sel;
			ind_mem_wdata <= ind.wdata;
			ind_rdata     <= self_sel ? INDIRECT_READ
			                          : ind_mem_rdata;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			aw_q          <= 8'h00;
			wd_q          <= 32'h0000_0000;
			ws_q          <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else if (clk_en) begin
			s_axi_awready <= ~aw_held & ~b_busy;
			s_axi_wready  <= ~w_held & ~b_busy;
			if (aw_take) begin
				aw_got_q <= 1'b1;
				aw_q     <= s_axi_awaddr;
			end
			if (w_take) begin
				w_got_q <= 1'b1;
				wd_q    <= s_axi_wdata;
				ws_q    <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end


	// ==========================================================
	// AXI4-Lite read path
	logic [31:0]     rd_mux;
	logic            rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			PC_LOW_BYTE_OFF:   rd_mux = {24'h0, pc_q[7:0]};
			PC_HIGH_LATCH_OFF: rd_mux = {24'h0, latch_q};
			FILE_SELECT_OFF:   rd_mux = {24'h0, fsel_q};
			PC_FULL_OFF:       rd_mux = {19'h0, pc_q};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_ok  = 1'b0;
			end
		endcase
	end

	wire             r_busy   = (s_axi_arvalid & s_axi_arready) |
	                            (s_axi_rvalid & ~s_axi_rready);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (clk_en) begin
			s_axi_arready <= ~r_busy;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign pc = pc_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	low_write_load_a: assert property (clk_en & flow.low_wr |=>
		pc[12:8] == $past(latch_q[4:0]) &&
		pc[7:0] == $past(flow.low_data))
		else $error("low byte write did not load counter");
	jump_target_a: assert property (clk_en & ~any_low &
		(flow.op == PCS_JUMP) |=>
		pc == {$past(latch_q[4:3]), $past(flow.target)})
		else $error("jump target wrong");
	push_pop_a: assert property (clk_en & ~any_low &
		(flow.op == PCS_CALL) ##1 clk_en & ~any_low &
		(flow.op == PCS_RETURN) |=> pc == $past(pc, 2) + 13'h0001)
		else $error("return did not restore call address");
	latch_steady_a: assert property (clk_en & ~wr_latch &
		(flow.op inside {PCS_CALL, PCS_RETURN, PCS_VECTOR}) |=>
		$stable(latch_q))
		else $error("latch moved on stack action");
	ptr_wrap_a: assert property (clk_en & (flow.op == PCS_CALL) |=>
		sp_q == $past(sp_q) + 3'h1)
		else $error("stack pointer did not advance");
	pop_wrap_a: assert property (clk_en & (flow.op == PCS_RETURN) |=>
		sp_q == $past(sp_q) - 3'h1)
		else $error("stack pointer did not retreat");
	self_read_a: assert property (clk_en & self_sel |=>
		ind_rdata == 8'h00 && !ind_mem_wr)
		else $error("indirect self access not blocked");
	bank_addr_a: assert property (clk_en |=>
		ind_addr == {$past(ind.bank), $past(fsel_q)})
		else $error("indirect address wrong");
	hold_pc_a: assert property (!clk_en |=> $stable(pc))
		else $error("counter moved while disabled");

	call_cov: cover property (clk_en & (flow.op == PCS_CALL));
	ret_cov: cover property (clk_en & (flow.op == PCS_RETURN));
	ovf_cov: cover property (clk_en & do_push & (sp_q == 3'h7));
	ind_cov: cover property (clk_en & ind.rd & self_sel);

endmodule

`default_nettype wire

// *** tb/pcs_dmem.sv ***
// Data memory model that answers the indirect port.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Memory
module pcs_dmem (
	input  wire logic       clock,
	input  wire logic [8:0] addr,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata
);
	logic [7:0] mem_q [512];
	// Contents start as a known pattern so reads can be predicted.
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem_q[i] = i[7:0] ^ 8'ha5;
		end
	end
	always @(posedge clock) begin
		if (wr) begin
			mem_q[addr] <= wdata;
		end
	end
	assign rdata = mem_q[addr];
endmodule
`default_nettype wire

// *** tb/program_counter_stack_indirect_tb.sv ***
// Self-checking testbench for the program counter and stack block.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench
module program_counter_stack_indirect_tb import pcs_pkg::*;;
	typedef struct {
		pcs_op_type  op;
		logic [10:0] tgt;
		logic [12:0] vec;
		logic        lw;
		logic [7:0]  ld;
		logic [12:0] exp;
	} pcs_row_type;
	logic         clock, nrst, clk_en, ind_mem_wr, awvalid, awready;
	logic         wvalid, wready, bvalid, bready, arvalid, arready;
	logic         rvalid, rready;
	pcs_flow_type flow, hold_f, f;
	pcs_ind_type  ind;
	logic [7:0]   mem_rdata, ind_mem_wdata, ind_rdata, awaddr, araddr;
	logic [12:0]  pc, exp_pc;
	logic [12:0]  stk [8];
	logic [2:0]   sp;
	logic [8:0]   ind_addr;
	logic [31:0]  wdata, rdata, rd_d;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp, rd_r;
	int           errors, tests_run;
	pcs_row_type  rows [11];

	pcs_core u_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en),
		.flow(flow), .ind(ind), .ind_mem_rdata(mem_rdata), .pc(pc),
		.ind_addr(ind_addr), .ind_mem_wr(ind_mem_wr),
		.ind_mem_wdata(ind_mem_wdata), .ind_rdata(ind_rdata),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pcs_dmem u_mem (.clock(clock), .addr(ind_addr), .wr(ind_mem_wr),
		.wdata(ind_mem_wdata), .rdata(mem_rdata));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ==========================================================
	// Tasks
	task automatic give_verdict();
		$display("Counts: %0d compares, %0d errors", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic timeout();
		errors++;
		$display("Error at %0t: wait ran out", $time);
		give_verdict();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				rd_r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50) timeout();
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd_d = rdata;
				rd_r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50) timeout();
	endtask
	task automatic do_flow(input pcs_flow_type g);
		@(posedge clock);
		flow <= g;
		@(posedge clock);
		flow <= hold_f;
		#1;
	endtask
	task automatic ind_op(input logic b, rd, wr, input logic [7:0] d);
		@(posedge clock);
		ind <= '{bank: b, rd: rd, wr: wr, wdata: d};
		@(posedge clock);
		if (rd) @(posedge clock);
		ind <= '0;
		#1;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		hold_f = '{op: PCS_HOLD, target: '0, vector: '0, low_wr: 1'b0,
			low_data: '0};
		flow = hold_f;
		{nrst, ind, awaddr, awvalid, wvalid, bready} = '0;
		{araddr, arvalid, rready, wdata, errors, tests_run} = '0;
		clk_en = 1'b1;
		wstrb = 4'hf;
		rows = '{'{PCS_INC, 0, 0, 0, 0, 13'h0001},
			'{PCS_JUMP, 11'h0ab, 0, 0, 0, 13'h18ab},
			'{PCS_INC, 0, 0, 0, 0, 13'h18ac},
			'{PCS_HOLD, 0, 0, 0, 0, 13'h18ac},
			'{PCS_HOLD, 0, 0, 1, 8'hff, 13'h1dff},
			'{PCS_INC, 0, 0, 0, 0, 13'h1e00},
			'{PCS_INC, 0, 0, 1, 8'h10, 13'h1d10},
			'{PCS_CALL, 11'h123, 0, 0, 0, 13'h1923},
			'{PCS_RETURN, 0, 0, 0, 0, 13'h1d11},
			'{PCS_VECTOR, 0, 13'h0004, 0, 0, 13'h0004},
			'{PCS_RETURN, 0, 0, 0, 0, 13'h1d12}};
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		#1;
		check(pc, 13'h0);
		axi_wr(PC_HIGH_LATCH_OFF, 32'h1d);
		check(rd_r, RESP_OKAY);
		for (int i = 0; i < 11; i++) begin
			f = '{op: rows[i].op, target: rows[i].tgt, vector: rows[i].vec,
				low_wr: rows[i].lw, low_data: rows[i].ld};
			do_flow(f);
			check(pc, rows[i].exp);
		end
		$display("test rows done");
		exp_pc = 13'h1d12;
		sp = 3'h0;
		stk = '{default: '0};
		stk[0] = 13'h1d12;
		for (int i = 0; i < 19; i++) begin
			f = hold_f;
			f.op = (i < 9) ? PCS_CALL : PCS_RETURN;
			f.target = 11'(i * 8'h91);
			if (i < 9) begin
				stk[sp] = exp_pc + 13'h1;
				sp++;
				exp_pc = {2'b11, f.target};
			end else begin
				sp--;
				exp_pc = stk[sp];
			end
			do_flow(f);
			check(pc, exp_pc);
		end
		$display("test stack wrap done");
		axi_rd(PC_HIGH_LATCH_OFF);
		check(rd_d, 32'h1d);
		axi_rd(PC_FULL_OFF);
		check(rd_d, {19'h0, exp_pc});
		axi_rd(PC_LOW_BYTE_OFF);
		check(rd_d, {24'h0, exp_pc[7:0]});
		axi_rd(STACK_PTR_OFF);
		check(rd_r, RESP_SLVERR);
		axi_wr(PC_LOW_BYTE_OFF, 32'h42);
		check(pc, 13'h1d42);
		$display("test registers done");
		axi_wr(FILE_SELECT_OFF, 32'h20);
		ind_op(1'b1, 1'b0, 1'b1, 8'h5a);
		check(ind_addr, 9'h120);
		check(ind_mem_wr, 1'b1);
		ind_op(1'b1, 1'b1, 1'b0, 8'h0);
		check(ind_rdata, 8'h5a);
		ind_op(1'b0, 1'b1, 1'b0, 8'h0);
		check(ind_rdata, 8'h85);
		axi_wr(FILE_SELECT_OFF, 32'h0);
		ind_op(1'b0, 1'b0, 1'b1, 8'h77);
		check(ind_mem_wr, 1'b0);
		ind_op(1'b0, 1'b1, 1'b0, 8'h0);
		check(ind_rdata, 8'h00);
		$display("test indirect done");
		@(posedge clock);
		clk_en <= 1'b0;
		flow <= '{op: PCS_INC, target: '0, vector: '0, low_wr: 1'b0,
			low_data: '0};
		repeat (3) @(posedge clock);
		#1;
		check(pc, 13'h1d42);
		@(posedge clock);
		clk_en <= 1'b1;
		flow <= hold_f;
		#1;
		$display("test clock enable done");
		@(posedge clock);
		nrst <= 1'b0;
		@(posedge clock);
		nrst <= 1'b1;
		#1;
		check(pc, 13'h0);
		axi_rd(PC_HIGH_LATCH_OFF);
		check(rd_d, 32'h0);
		$display("test second reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
